// ==== common/xb_regs.vh ====
`ifndef XB_REGS_VH
`define XB_REGS_VH

// register byte offsets on the apb side
`define XB_OFF_BASE_HI      12'h000
`define XB_OFF_BASE_LO      12'h004
`define XB_OFF_BASE_STRIDE  12'h008
`define XB_OFF_OSC_CFG      12'h024
`define XB_OFF_MODE         12'h0F0
`define XB_OFF_STATUS       12'h0F4

// low base byte register fields
`define XB_LO_DIS_BIT       8
`define XB_LO_WP_BIT        9

// mode select register fields
`define XB_MODE_SEL_BIT     0
`define XB_MODE_RDW_LSB     1
`define XB_MODE_WRW_LSB     4
`define XB_MODE_W_BITS      3

// global oscillator configuration fields
`define XB_OSC_QUAL_BIT     6

// reset values
`define XB_MODE_RST         8'h00
`define XB_OSC_RST          8'h00
`define XB_BASE_RST         8'h00

// strobe framing times and clock period
`define XB_CLK_NS           50
`define XB_SETUP_NS         50
`define XB_HOLD_NS          50
`define XB_SETUP_CYC        ((`XB_SETUP_NS + `XB_CLK_NS - 1) / `XB_CLK_NS)
`define XB_HOLD_CYC         ((`XB_HOLD_NS + `XB_CLK_NS - 1) / `XB_CLK_NS)

`endif

// ==== logic/xb_addr_match.v ====
`timescale 1ns/100ps
`include "xb_regs.vh"

module xb_addr_match
#(
	parameter NSEL = 4
)
(
	input  wire [15:0]        host_addr,
	input  wire [16*NSEL-1:0] base_flat,
	input  wire [NSEL-1:0]    sel_disable,
	input  wire               mode_two,
	input  wire               qual_en,
	output wire [NSEL-1:0]    sel_hit
);

////////////////////////////////////////////////////////////////////////
// compare mask: which address bits take part in the match
function [15:0] xb_mask;
	input mode2;
	input qual;
	begin
		xb_mask = mode2 ? 16'hFFF0 : 16'hFFFC;
		if (!qual)
		begin
			xb_mask = xb_mask & 16'h0FFF;
		end
	end
endfunction

wire [15:0] cmp_mask;
wire        top_zero;

// low bits left out of the mask give each select four ports, sixteen in the second mode [RULE1]
assign cmp_mask = xb_mask(mode_two, qual_en);
// full qualification demands a clear top nibble [RULE9]
assign top_zero = ~qual_en | (host_addr[15:12] == 4'h0);

////////////////////////////////////////////////////////////////////////
// one comparator per select
genvar gi;
generate
	for (gi = 0; gi < NSEL; gi = gi + 1)
	begin : g_sel
		wire [15:0] base_w;
		wire        in_mode;
		assign base_w  = base_flat[16*gi +: 16];
		// second mode only owns the two lowest selects [RULE2]
		assign in_mode = ~mode_two | (gi < 2);
		// compare against the programmed base [RULE4] [RULE6] [RULE7]
		assign sel_hit[gi] = in_mode & ~sel_disable[gi] & top_zero &
			(((host_addr ^ base_w) & cmp_mask) == 16'h0000); // [RULE12]
	end
endgenerate

endmodule // xb_addr_match

// ==== logic/xb_phase_timer.v ====
`timescale 1ns/100ps

module xb_phase_timer
#(
	parameter W = 4
)
(
	input  wire         sys_clk,
	input  wire         rst,
	input  wire         load,
	input  wire [W-1:0] length,
	output wire         expired
);

reg [W-1:0] cnt_ff;
reg [W-1:0] nxt_cnt;

////////////////////////////////////////////////////////////////////////
// counts down a phase of length cycles, loaded with length minus one
always @*
begin
	nxt_cnt = cnt_ff;
	if (load)
	begin
		nxt_cnt = length - {{(W-1){1'b0}}, 1'b1};
	end
	else if (cnt_ff != {W{1'b0}})
	begin
		nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
	end
end

always @(posedge sys_clk)
begin
	if (rst)
	begin
		cnt_ff <= {W{1'b0}};
	end
	else
	begin
		cnt_ff <= nxt_cnt;
	end
end

// straight from the count: the caller feeds expired back into load
assign expired = (cnt_ff == {W{1'b0}});

endmodule // xb_phase_timer

// ==== logic/xb_expansion.v ====
// Operation
// RULE1 - up to four external byte-wide peripherals, each up to sixteen ports.
// RULE2 - first mode: four selects and two address pins; second: two and four.
// RULE3 - a read strobe, a write strobe and an eight-bit data bus are driven.
// RULE4 - each select comes from comparing the host address with its base.
// RULE5 - bit 0 of the mode select register at 0xF0 picks the mode.
// RULE6 - first mode compares bits 15..2 and passes bits 1..0 through.
// RULE7 - second mode compares bits 15..4 and passes bits 3..0 through.
// RULE8 - a select is low only during the host cycle that matched it.
// RULE9 - qualification covers 16 bits and needs the top nibble zero.
// RULE10 - software sets bit 6 of the oscillator config for 16-bit decode.
// RULE11 - strobes assert only in a cycle whose address matched.
// RULE12 - each select has a disable bit in its low base register.
// RULE13 - each select has a set-once write protect bit cleared by reset.
// RULE14 - a protected select rejects writes to its high and low base regs.
// RULE15 - the mode select register also sets the strobe pulse widths.
// RULE16 - matched reads return the bus byte; writes drive the data bus.
// RULE17 - a blocked write completes normally and changes nothing.
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`include "xb_regs.vh"

module xb_expansion
#(
	parameter NSEL = 4
)
(
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        hard_host_reset_n,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        host_io_req,
	input  wire        host_io_write,
	input  wire [15:0] host_io_addr,
	input  wire [7:0]  host_io_wdata,
	output reg         host_io_ready,
	output reg         host_io_done,
	output reg         host_io_hit,
	output reg  [7:0]  host_io_rdata,
	output reg  [3:0]  peripheral_select_n,
	output reg  [3:0]  peripheral_addr,
	output reg         peripheral_read_strobe_n,
	output reg         peripheral_write_strobe_n,
	input  wire [7:0]  peripheral_data_in,
	output reg  [7:0]  peripheral_data_out,
	output reg         peripheral_data_oe
);

localparam ST_IDLE   = 5'b00001;
localparam ST_SETUP  = 5'b00010;
localparam ST_STROBE = 5'b00100;
localparam ST_HOLD   = 5'b01000;
localparam ST_DONE   = 5'b10000;

////////////////////////////////////////////////////////////////////////
// configuration and sequencer state
reg  [7:0]         base_hi_ff [0:NSEL-1];
reg  [7:0]         base_lo_ff [0:NSEL-1];
reg  [NSEL-1:0]    dis_ff;
reg  [NSEL-1:0]    wp_ff;
reg  [7:0]         mode_ff;
reg  [7:0]         osc_ff;
reg  [NSEL-1:0]    last_hit_ff;
reg  [4:0]         state_ff;
reg                is_write_ff;

wire               cfg_rst;
wire               acc;
wire               wr_acc;
wire [16*NSEL-1:0] base_flat;
wire [NSEL-1:0]    sel_hit;
wire               tmr_exp;
reg                tmr_load;
reg  [3:0]         tmr_len;
reg  [3:0]         sel_n_mode;
wire [31:0]        setup_cyc_w;
wire [31:0]        hold_cyc_w;

// phase lengths in cycles, cut to the timer width where used
assign setup_cyc_w = `XB_SETUP_CYC;
assign hold_cyc_w  = `XB_HOLD_CYC;

// both power-on and hard host reset clear the set-once bits [RULE13]
assign cfg_rst = rst | ~hard_host_reset_n;
assign acc     = psel & penable & pready;
assign wr_acc  = acc & pwrite;

genvar gi;
generate
	for (gi = 0; gi < NSEL; gi = gi + 1)
	begin : g_flat
		assign base_flat[16*gi +: 16] = {base_hi_ff[gi], base_lo_ff[gi]};
	end
endgenerate

////////////////////////////////////////////////////////////////////////
// decode helpers
function is_hi;
	input [11:0] a;
	input integer i;
	begin
		is_hi = (a == (`XB_OFF_BASE_HI + `XB_OFF_BASE_STRIDE * i[11:0]));
	end
endfunction

function is_lo;
	input [11:0] a;
	input integer i;
	begin
		is_lo = (a == (`XB_OFF_BASE_LO + `XB_OFF_BASE_STRIDE * i[11:0]));
	end
endfunction

function [3:0] width_of;
	input [2:0] fld;
	begin
		width_of = {1'b0, fld} + 4'h1;
	end
endfunction

////////////////////////////////////////////////////////////////////////
// base address matching
xb_addr_match
#(
	.NSEL (NSEL)
)
u_match
(
	.host_addr   (host_io_addr),
	.base_flat   (base_flat),
	.sel_disable (dis_ff),
	.mode_two    (mode_ff[`XB_MODE_SEL_BIT]),               // [RULE5]
	.qual_en     (osc_ff[`XB_OSC_QUAL_BIT]),                // [RULE10]
	.sel_hit     (sel_hit)
);

////////////////////////////////////////////////////////////////////////
// setup, strobe and hold phase timer
xb_phase_timer
#(
	.W (4)
)
u_timer
(
	.sys_clk (sys_clk),
	.rst     (rst),
	.load    (tmr_load),
	.length  (tmr_len),
	.expired (tmr_exp)
);

////////////////////////////////////////////////////////////////////////
// apb handshake: one wait-free access phase
always @(posedge sys_clk)
begin
	if (rst)
	begin
		pready <= 1'b0;
	end
	else
	begin
		pready <= psel & ~penable;
	end
end

////////////////////////////////////////////////////////////////////////
// base registers with disable and set-once protect
integer i;
always @(posedge sys_clk)
begin
	if (cfg_rst)
	begin
		for (i = 0; i < NSEL; i = i + 1)
		begin
			base_hi_ff[i] <= `XB_BASE_RST;
			base_lo_ff[i] <= `XB_BASE_RST;
		end
		dis_ff <= {NSEL{1'b0}};
		wp_ff  <= {NSEL{1'b0}};
	end
	else if (wr_acc)
	begin
		for (i = 0; i < NSEL; i = i + 1)
		begin
			// protected selects silently ignore writes [RULE14] [RULE17]
			if (is_hi(paddr, i) && !wp_ff[i])
			begin
				base_hi_ff[i] <= pwdata[7:0];
			end
			else if (is_lo(paddr, i) && !wp_ff[i])
			begin
				base_lo_ff[i] <= pwdata[7:0];
				dis_ff[i]     <= pwdata[`XB_LO_DIS_BIT];       // [RULE12]
				wp_ff[i]      <= pwdata[`XB_LO_WP_BIT];        // [RULE13]
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////
// mode and oscillator configuration
always @(posedge sys_clk)
begin
	if (cfg_rst)
	begin
		mode_ff <= `XB_MODE_RST;
		osc_ff  <= `XB_OSC_RST;
	end
	else if (wr_acc)
	begin
		if (paddr == `XB_OFF_MODE)
		begin
			mode_ff <= pwdata[7:0];                            // [RULE15]
		end
		else if (paddr == `XB_OFF_OSC_CFG)
		begin
			osc_ff <= pwdata[7:0];
		end
	end
end

////////////////////////////////////////////////////////////////////////
// read data and error answer, given in the access phase
reg [31:0] nxt_rdata;
reg        nxt_err;
integer    k;
always @*
begin
	nxt_rdata = 32'h0000_0000;
	nxt_err   = 1'b1;
	if (paddr == `XB_OFF_MODE)
	begin
		nxt_rdata = {24'h000000, mode_ff};
		nxt_err   = 1'b0;
	end
	else if (paddr == `XB_OFF_OSC_CFG)
	begin
		nxt_rdata = {24'h000000, osc_ff};
		nxt_err   = 1'b0;
	end
	else if (paddr == `XB_OFF_STATUS)
	begin
		nxt_rdata[3:0]  = last_hit_ff;
		nxt_rdata[4]    = ~state_ff[0];
		nxt_rdata[11:8] = wp_ff;
		nxt_err         = 1'b0;
	end
	for (k = 0; k < NSEL; k = k + 1)
	begin
		if (is_hi(paddr, k))
		begin
			nxt_rdata = {24'h000000, base_hi_ff[k]};
			nxt_err   = 1'b0;
		end
		else if (is_lo(paddr, k))
		begin
			nxt_rdata = {22'h0, wp_ff[k], dis_ff[k], base_lo_ff[k]};
			nxt_err   = 1'b0;
		end
	end
end

always @(posedge sys_clk)
begin
	if (rst)
	begin
		prdata  <= 32'h0000_0000;
		pslverr <= 1'b0;
	end
	else if (psel && !penable)
	begin
		prdata  <= pwrite ? 32'h0000_0000 : nxt_rdata;
		pslverr <= nxt_err;
	end
	else
	begin
		prdata  <= 32'h0000_0000;
		pslverr <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////
// select mask per mode: unused selects stay high in the second mode
always @*
begin
	sel_n_mode = ~sel_hit;
	if (mode_ff[`XB_MODE_SEL_BIT])
	begin
		sel_n_mode[3:2] = 2'b11;                               // [RULE2]
	end
end

////////////////////////////////////////////////////////////////////////
// timer loads at each phase change
always @*
begin
	tmr_load = 1'b0;
	tmr_len  = 4'h1;
	case (state_ff)
		ST_IDLE:
		begin
			tmr_load = host_io_req & (|sel_hit);
			tmr_len  = setup_cyc_w[3:0];
		end
		ST_SETUP:
		begin
			tmr_load = tmr_exp;
			tmr_len  = is_write_ff ?
				width_of(mode_ff[`XB_MODE_WRW_LSB +: `XB_MODE_W_BITS]) :
				width_of(mode_ff[`XB_MODE_RDW_LSB +: `XB_MODE_W_BITS]);
		end
		ST_STROBE:
		begin
			tmr_load = tmr_exp;
			tmr_len  = hold_cyc_w[3:0];
		end
		default:
		begin
			tmr_load = 1'b0;
		end
	endcase
end

////////////////////////////////////////////////////////////////////////
// host cycle sequencer driving the peripheral pins
always @(posedge sys_clk)
begin
	if (rst)
	begin
		state_ff                  <= ST_IDLE;
		is_write_ff               <= 1'b0;
		last_hit_ff               <= {NSEL{1'b0}};
		host_io_ready             <= 1'b1;
		host_io_done              <= 1'b0;
		host_io_hit               <= 1'b0;
		host_io_rdata             <= 8'hFF;
		peripheral_select_n       <= 4'hF;
		peripheral_addr           <= 4'h0;
		peripheral_read_strobe_n  <= 1'b1;
		peripheral_write_strobe_n <= 1'b1;
		peripheral_data_out       <= 8'h00;
		peripheral_data_oe        <= 1'b0;
	end
	else
	begin
		host_io_done <= 1'b0;
		case (state_ff)
			ST_IDLE:
			begin
				if (host_io_req)
				begin
					host_io_ready <= 1'b0;
					is_write_ff   <= host_io_write;
					last_hit_ff   <= sel_hit;
					host_io_hit   <= |sel_hit;
					host_io_rdata <= 8'hFF;
					if (|sel_hit)
					begin
						// select low only for the matched cycle [RULE8]
						peripheral_select_n <= sel_n_mode;
						// pass low address bits [RULE6] [RULE7]
						peripheral_addr <= mode_ff[`XB_MODE_SEL_BIT] ?
							host_io_addr[3:0] :
							{2'b00, host_io_addr[1:0]};
						peripheral_data_out <= host_io_wdata;   // [RULE16]
						peripheral_data_oe  <= host_io_write;   // [RULE3]
						state_ff            <= ST_SETUP;
					end
					else
					begin
						state_ff <= ST_DONE;
					end
				end
			end
			ST_SETUP:
			begin
				if (tmr_exp)
				begin
					// strobes only inside a matched cycle [RULE11]
					peripheral_read_strobe_n  <= is_write_ff;
					peripheral_write_strobe_n <= ~is_write_ff;
					state_ff                  <= ST_STROBE;
				end
			end
			ST_STROBE:
			begin
				if (tmr_exp)
				begin
					peripheral_read_strobe_n  <= 1'b1;
					peripheral_write_strobe_n <= 1'b1;
					if (!is_write_ff)
					begin
						host_io_rdata <= peripheral_data_in;    // [RULE16]
					end
					state_ff <= ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				if (tmr_exp)
				begin
					peripheral_select_n <= 4'hF;                // [RULE8]
					peripheral_data_oe  <= 1'b0;
					state_ff            <= ST_DONE;
				end
			end
			ST_DONE:
			begin
				host_io_done  <= 1'b1;
				host_io_ready <= 1'b1;
				state_ff      <= ST_IDLE;
			end
			default:
			begin
				state_ff <= ST_IDLE;
			end
		endcase
	end
end

endmodule // xb_expansion

// ==== bench/xb_expansion_sva.sv ====
`timescale 1ns/100ps
module xb_expansion_sva
(
	input wire        sys_clk,
	input wire        rst,
	input wire        psel,
	input wire        penable,
	input wire        pready,
	input wire        host_io_req,
	input wire        host_io_ready,
	input wire        host_io_done,
	input wire        host_io_hit,
	input wire [15:0] host_io_addr,
	input wire [7:0]  host_io_rdata,
	input wire [3:0]  peripheral_select_n,
	input wire [3:0]  peripheral_addr,
	input wire        peripheral_read_strobe_n,
	input wire        peripheral_write_strobe_n,
	input wire        peripheral_data_oe
);
	logic [15:0] acc_ff;
	// address of the host cycle last accepted
	always @(posedge sys_clk)
	begin
		if (host_io_req && host_io_ready)
			acc_ff <= host_io_addr;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	idle_sel_a: assert property (host_io_ready |-> peripheral_select_n == 4'hF)
		else $error("select low while idle");
	rd_sel_a: assert property (!peripheral_read_strobe_n |-> peripheral_select_n != 4'hF)
		else $error("read strobe without select");
	wr_sel_a: assert property (!peripheral_write_strobe_n |-> peripheral_select_n != 4'hF)
		else $error("write strobe without select");
	one_strobe_a: assert property (peripheral_read_strobe_n || peripheral_write_strobe_n)
		else $error("both strobes low");
	wr_drive_a: assert property (!peripheral_write_strobe_n |-> peripheral_data_oe)
		else $error("write strobe with bus released");
	rd_float_a: assert property (!peripheral_read_strobe_n |-> !peripheral_data_oe)
		else $error("read strobe with bus driven");
	strobe_setup_a: assert property (($fell(peripheral_read_strobe_n) || $fell(peripheral_write_strobe_n)) |-> $past(peripheral_select_n) != 4'hF)
		else $error("strobe without select setup");
	addr_pass_a: assert property (peripheral_select_n != 4'hF |-> peripheral_addr[1:0] == acc_ff[1:0])
		else $error("address pins differ from host address");
	miss_done_a: assert property ((host_io_req && host_io_ready) ##1 !host_io_hit |-> ##[0:2] host_io_done)
		else $error("unmatched cycle not finished");
	miss_data_a: assert property (host_io_done && !host_io_hit |-> host_io_rdata == 8'hFF)
		else $error("unmatched read returned data");
	apb_ready_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	apb_pulse_a: assert property (pready |=> !pready)
		else $error("ready held over two cycles");
	cover property (host_io_done && host_io_hit);
	cover property (!peripheral_write_strobe_n);
	cover property ($fell(peripheral_read_strobe_n));
endmodule // xb_expansion_sva

// ==== bench/xb_periph_model.sv ====
`timescale 1ns/100ps
module xb_periph_model
(
	input wire         sys_clk,
	input wire [3:0]   peripheral_select_n,
	input wire [3:0]   peripheral_addr,
	input wire         peripheral_read_strobe_n,
	input wire         peripheral_write_strobe_n,
	input wire [7:0]   peripheral_data_out,
	input wire         peripheral_data_oe,
	output logic [7:0] peripheral_data_in,
	output logic [7:0] last_write
);
	logic [7:0] held = 8'h00;
	wire        drive = !peripheral_read_strobe_n && peripheral_select_n != 4'hF;
	// answer a read with a pattern of the port address, else the inverse of the last pattern driven
	assign peripheral_data_in = drive ? {peripheral_addr, ~peripheral_addr} : ~held;
	// remember the last driven byte and the byte written in
	always @(posedge sys_clk)
	begin
		if (drive)
			held <= {peripheral_addr, ~peripheral_addr};
		if (!peripheral_write_strobe_n && peripheral_select_n != 4'hF && peripheral_data_oe)
			last_write <= peripheral_data_out;
	end
endmodule // xb_periph_model

// ==== bench/testbench.sv ====
`timescale 1ns/100ps
`include "xb_regs.vh"
module testbench;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        hard_host_reset_n = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic        host_io_req = 1'b0;
	logic        host_io_write = 1'b0;
	logic [15:0] host_io_addr = 16'h0000;
	logic [7:0]  host_io_wdata = 8'h00;
	wire  [31:0] prdata;
	wire         pready, pslverr, host_io_ready, host_io_done, host_io_hit;
	wire  [7:0]  host_io_rdata, peripheral_data_in, peripheral_data_out;
	wire  [7:0]  last_write;
	wire  [3:0]  peripheral_select_n, peripheral_addr;
	wire         peripheral_read_strobe_n, peripheral_write_strobe_n;
	wire         peripheral_data_oe;
	integer      errors = 0;
	integer      comparisons = 0;
	integer      rd_w, wr_w;
	logic [31:0] rd_v;
	logic        err_v;
	always #25 sys_clk = ~sys_clk;
	xb_expansion #(.NSEL(4)) uut
	(
		.sys_clk                   (sys_clk),
		.rst                       (rst),
		.hard_host_reset_n         (hard_host_reset_n),
		.paddr                     (paddr),
		.psel                      (psel),
		.penable                   (penable),
		.pwrite                    (pwrite),
		.pwdata                    (pwdata),
		.prdata                    (prdata),
		.pready                    (pready),
		.pslverr                   (pslverr),
		.host_io_req               (host_io_req),
		.host_io_write             (host_io_write),
		.host_io_addr              (host_io_addr),
		.host_io_wdata             (host_io_wdata),
		.host_io_ready             (host_io_ready),
		.host_io_done              (host_io_done),
		.host_io_hit               (host_io_hit),
		.host_io_rdata             (host_io_rdata),
		.peripheral_select_n       (peripheral_select_n),
		.peripheral_addr           (peripheral_addr),
		.peripheral_read_strobe_n  (peripheral_read_strobe_n),
		.peripheral_write_strobe_n (peripheral_write_strobe_n),
		.peripheral_data_in        (peripheral_data_in),
		.peripheral_data_out       (peripheral_data_out),
		.peripheral_data_oe        (peripheral_data_oe)
	);
	xb_periph_model model
	(
		.sys_clk                   (sys_clk),
		.peripheral_select_n       (peripheral_select_n),
		.peripheral_addr           (peripheral_addr),
		.peripheral_read_strobe_n  (peripheral_read_strobe_n),
		.peripheral_write_strobe_n (peripheral_write_strobe_n),
		.peripheral_data_out       (peripheral_data_out),
		.peripheral_data_oe        (peripheral_data_oe),
		.peripheral_data_in        (peripheral_data_in),
		.last_write                (last_write)
	);
	////////////////////////////////////////////////////////////////////////
	task final_report;
		begin
			$display("errors %0d comparisons %0d", errors, comparisons);
			if (errors == 0 && comparisons > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task timeout;
		begin
			errors = errors + 1;
			final_report;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp)
			begin
				errors = errors + 1;
				$display("wrong value at %0t: %h not %h", $time, got, exp);
			end
		end
	endtask
	// one apb transfer, held until pready is seen high
	task apb(input [11:0] a, input w, input [31:0] d);
		integer n;
		begin
			@(posedge sys_clk);
			psel <= 1'b1;
			paddr <= a;
			pwrite <= w;
			pwdata <= d;
			@(posedge sys_clk);
			penable <= 1'b1;
			n = 0;
			@(posedge sys_clk);
			while (pready !== 1'b1 && n < 40)
			begin
				n = n + 1;
				@(posedge sys_clk);
			end
			if (pready !== 1'b1)
				timeout;
			rd_v = prdata;
			err_v = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task base(input [1:0] i, input [15:0] b, input dis);
		begin
			apb({7'h00, i, 3'h0}, 1'b1, {24'h000000, b[15:8]});
			apb({7'h00, i, 3'h4}, 1'b1, {23'h000000, dis, b[7:0]});
		end
	endtask
	// one host cycle; checks selects, address pins, strobes and data
	task host(input w, input [15:0] a, input [3:0] es, input [3:0] ea,
		input [7:0] ed);
		integer n;
		logic [3:0] s, pa;
		begin
			s = 4'hF;
			pa = 4'h0;
			rd_w = 0;
			wr_w = 0;
			@(posedge sys_clk);
			host_io_req <= 1'b1;
			host_io_write <= w;
			host_io_addr <= a;
			host_io_wdata <= ed;
			n = 0;
			@(posedge sys_clk);
			while (host_io_ready !== 1'b1 && n < 40)
			begin
				n = n + 1;
				@(posedge sys_clk);
			end
			if (host_io_ready !== 1'b1)
				timeout;
			host_io_req <= 1'b0;
			n = 0;
			@(posedge sys_clk);
			while (host_io_done !== 1'b1 && n < 40)
			begin
				s = s & peripheral_select_n;
				if (peripheral_select_n !== 4'hF)
					pa = peripheral_addr;
				rd_w = rd_w + !peripheral_read_strobe_n;
				wr_w = wr_w + !peripheral_write_strobe_n;
				n = n + 1;
				@(posedge sys_clk);
			end
			if (host_io_done !== 1'b1)
				timeout;
			chk(s, es);
			chk(pa, ea);
			chk(host_io_hit, es != 4'hF);
			if (es == 4'hF)
			begin
				chk(rd_w + wr_w, 0);
				chk(host_io_rdata, 8'hFF);
			end
			else
			begin
				chk(w ? rd_w : wr_w, 0);
				chk(w ? last_write : host_io_rdata, ed);
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_mode1;
		begin
			apb(12'h0FC, 1'b0, 32'h0);
			chk(err_v, 1'b1);
			apb(`XB_OFF_MODE, 1'b0, 32'h0);
			chk(rd_v, 32'h00000000);
			apb(`XB_OFF_OSC_CFG, 1'b1, 32'h40);
			apb(`XB_OFF_MODE, 1'b1, 32'h0E);
			apb(`XB_OFF_MODE, 1'b0, 32'h0);
			chk(rd_v, 32'h0000000E);
			base(2'd0, 16'h0300, 1'b0);
			base(2'd1, 16'h0310, 1'b0);
			base(2'd2, 16'h0320, 1'b1);
			base(2'd3, 16'h0330, 1'b0);
			host(1'b0, 16'h0302, 4'hE, 4'h2, 8'h2D);
			chk(rd_w, 8);
			host(1'b1, 16'h0311, 4'hD, 4'h1, 8'hA5);
			chk(wr_w, 1);
			host(1'b0, 16'h0322, 4'hF, 4'h0, 8'h00);
			host(1'b0, 16'h0333, 4'h7, 4'h3, 8'h3C);
			host(1'b0, 16'h0304, 4'hF, 4'h0, 8'h00);
			host(1'b0, 16'h1300, 4'hF, 4'h0, 8'h00);
			apb(`XB_OFF_OSC_CFG, 1'b1, 32'h00);
			host(1'b0, 16'h1300, 4'hE, 4'h0, 8'h0F);
		end
	endtask
	task t_mode2;
		begin
			apb(`XB_OFF_MODE, 1'b1, 32'h01);
			host(1'b0, 16'h031A, 4'hD, 4'hA, 8'hA5);
			chk(rd_w, 1);
			host(1'b1, 16'h030F, 4'hE, 4'hF, 8'h5A);
		end
	endtask
	task t_protect;
		begin
			apb(12'h004, 1'b1, 32'h200);
			apb(12'h000, 1'b1, 32'h05);
			chk(err_v, 1'b0);
			apb(12'h000, 1'b0, 32'h0);
			chk(rd_v, 32'h00000003);
			apb(12'h004, 1'b1, 32'h100);
			apb(12'h004, 1'b0, 32'h0);
			chk(rd_v, 32'h00000200);
			host(1'b0, 16'h0301, 4'hE, 4'h1, 8'h1E);
			apb(`XB_OFF_STATUS, 1'b0, 32'h0);
			chk(rd_v, 32'h00000101);
			@(posedge sys_clk);
			hard_host_reset_n <= 1'b0;
			@(posedge sys_clk);
			hard_host_reset_n <= 1'b1;
			apb(12'h004, 1'b0, 32'h0);
			chk(rd_v, 32'h00000000);
			apb(12'h000, 1'b1, 32'h05);
			apb(12'h000, 1'b0, 32'h0);
			chk(rd_v, 32'h00000005);
		end
	endtask
	// reset, then the scenarios in turn
	initial
	begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		t_mode1;
		t_mode2;
		t_protect;
		final_report;
	end
endmodule // testbench
bind xb_expansion xb_expansion_sva chk
(
	.sys_clk                   (sys_clk),
	.rst                       (rst),
	.psel                      (psel),
	.penable                   (penable),
	.pready                    (pready),
	.host_io_req               (host_io_req),
	.host_io_ready             (host_io_ready),
	.host_io_done              (host_io_done),
	.host_io_hit               (host_io_hit),
	.host_io_addr              (host_io_addr),
	.host_io_rdata             (host_io_rdata),
	.peripheral_select_n       (peripheral_select_n),
	.peripheral_addr           (peripheral_addr),
	.peripheral_read_strobe_n  (peripheral_read_strobe_n),
	.peripheral_write_strobe_n (peripheral_write_strobe_n),
	.peripheral_data_oe        (peripheral_data_oe)
);
